// [hw/acc_pkg.sv]
// constants, field layouts and carrier types of the analog comparator control block
// assumes one 125 MHz clock domain shared with the bus master and the analog core control
// Function
// [R1] start task runs comparator, stop task halts it
// [R2] ready event after startup delay following start
// [R3] crossing events only while comparator is started
// [R4] upward crossing raises up, downward raises down
// [R5] cross event on every transition, either direction
// [R6] sample task captures output level into result
// [R7] enabling this comparator disables low-power comparator, vice versa
// [R8] software avoids sharing analog pins with sampling_adc
// [R9] software disables only after comparator has stopped
// [R10] differential hysteresis applied when hysteresis_enable set
// [R11] single-ended hysteresis uses upper/lower ladder thresholds
// [R12] negative input: pin zero/one, or reference
// [R13] reference: supply, pin zero/one, 1.2/1.8/2.4 V
// [R14] ladder thresholds offer 64 levels from reference
// [R15] mode selects differential/single-ended and three speeds
// [R16] current source sinks when output high, sources when low
// [R17] software configures inputs, mode, thresholds before enabling
// [R18] hysteresis_enable writes ignored in single-ended operation
// [R19] event flags sticky until cleared, individually maskable
package acc_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_TASK_START = 12'h000;
    localparam logic [11:0] OFS_TASK_STOP = 12'h004;
    localparam logic [11:0] OFS_TASK_SAMPLE = 12'h008;
    localparam logic [11:0] OFS_EVT_READY = 12'h100;
    localparam logic [11:0] OFS_EVT_DOWN = 12'h104;
    localparam logic [11:0] OFS_EVT_UP = 12'h108;
    localparam logic [11:0] OFS_EVT_CROSS = 12'h10c;
    localparam logic [11:0] OFS_EVT_STATUS = 12'h110;
    localparam logic [11:0] OFS_EVT_CLEAR = 12'h114;
    localparam logic [11:0] OFS_SHORTS = 12'h200;
    localparam logic [11:0] OFS_INTEN = 12'h300;
    localparam logic [11:0] OFS_INTENSET = 12'h304;
    localparam logic [11:0] OFS_INTENCLR = 12'h308;
    localparam logic [11:0] OFS_RESULT = 12'h400;
    localparam logic [11:0] OFS_ENABLE = 12'h500;
    localparam logic [11:0] OFS_PSEL = 12'h504;
    localparam logic [11:0] OFS_REFERENCE_SOURCE_SELECT = 12'h508;
    localparam logic [11:0] OFS_EXTERNAL_REFERENCE_PIN_SELECT = 12'h50c;
    localparam logic [11:0] OFS_THRESH = 12'h530;
    localparam logic [11:0] OFS_MODE = 12'h534;
    localparam logic [11:0] OFS_HYSTERESIS_ENABLE = 12'h538;
    localparam logic [11:0] OFS_CURRENT_SOURCE_SELECT = 12'h53c;
    // event bit positions, shared by status, clear and interrupt enable
    localparam int EV_READY = 0;
    localparam int EV_DOWN = 1;
    localparam int EV_UP = 2;
    localparam int EV_CROSS = 3;
    // shortcut bit positions
    localparam int SH_READY_SAMPLE = 0;
    localparam int SH_READY_STOP = 1;
    localparam int SH_DOWN_STOP = 2;
    localparam int SH_UP_STOP = 3;
    localparam int SH_CROSS_STOP = 4;
    // field positions
    localparam int TH_DOWN_LSB = 0;
    localparam int TH_UP_LSB = 8;
    localparam int MODE_SPEED_LSB = 0;
    localparam int MODE_DIFF_BIT = 8;
    // reference_source_select codes
    localparam logic [2:0] REF_INT_1V2 = 3'h0;
    localparam logic [2:0] REF_INT_1V8 = 3'h1;
    localparam logic [2:0] REF_INT_2V4 = 3'h2;
    localparam logic [2:0] REF_SUPPLY = 3'h3;
    localparam logic [2:0] REF_EXT_PIN = 3'h4;
    // speed codes
    localparam logic [1:0] SPEED_LOW_POWER = 2'h0;
    localparam logic [1:0] SPEED_NORMAL = 2'h1;
    localparam logic [1:0] SPEED_HIGH = 2'h2;
    // reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [13:0] RST_THRESH = 14'h0000;
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int STARTUP_NS = 10000;
    localparam int STARTUP_CYC = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [10:0] STARTUP_LAST = 11'(STARTUP_CYC - 1);

    typedef enum logic [2:0] {
        ACC_IDLE = 3'b001,
        ACC_STARTING = 3'b010,
        ACC_RUN = 3'b100
    } acc_state_t;

    // control word towards the analog core
    typedef struct packed {
        logic power_on;
        logic diff_mode;
        logic [1:0] speed;
        logic hysteresis_enable_on;
        logic neg_from_pin_one;
        logic [2:0] ref_select;
        logic ext_pin_one;
        logic [5:0] ladder_code;
        logic [2:0] positive_pin;
        logic [1:0] current_source_select;
        logic current_sink;
    } acc_ana_t;
endpackage : acc_pkg

// [hw/acc_sync_edge.sv]
// two-stage synchroniser with edge detection for the comparator core output
// assumes the core output is asynchronous to hclk
`timescale 1ns/10ps
module acc_sync_edge import acc_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic async_in,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // meta_r feeds sync_r only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else if (ce) begin
            meta_r <= async_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise = sync_r & ~prev_r;
    assign fall = ~sync_r & prev_r;
endmodule : acc_sync_edge

// [hw/acc_comparator_ctrl.sv]
// control logic of the voltage comparator: tasks, events, interrupt and analog core control
// assumes an AHB-Lite master on hclk and an analog core whose output is asynchronous
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module acc_comparator_ctrl import acc_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic core_out,
    input wire logic low_power_comparator_enabling,
    output logic low_power_comparator_disable,
    output acc_ana_t ana_ctrl,
    output logic irq
);
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    acc_state_t st_r;
    acc_state_t st_nxt;
    logic [10:0] cnt_r;
    logic wr_pend_r;
    logic [11:0] wr_addr_r;
    logic en_r;
    logic [4:0] shorts_r;
    logic [3:0] inten_r;
    logic [3:0] evt_r;
    logic [3:0] evt_nxt;
    logic result_r;
    logic [2:0] psel_r;
    logic [2:0] reference_source_select_r;
    logic extref_r;
    logic [5:0] thdown_r;
    logic [5:0] thup_r;
    logic [1:0] speed_r;
    logic diff_r;
    logic hysteresis_enable_r;
    logic [1:0] isrc_r;
    logic lvl;
    logic rise;
    logic fall;
    logic wr;
    logic [31:0] rd_val;
    logic start_wr;
    logic stop_wr;
    logic sample_wr;
    logic ready_ev;
    logic up_ev;
    logic down_ev;
    logic cross_ev;
    logic stop_req;
    logic sample_req;
    logic [3:0] clr;

    acc_sync_edge u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .async_in(core_out),
        .level(lvl),
        .rise(rise),
        .fall(fall)
    );

    // bus: address phase latched, write done in the data phase; zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end else if (ce && hready) begin
            wr_pend_r <= hsel & htrans[1] & hwrite & (hsize == 3'h2);
            wr_addr_r <= haddr[11:0];
        end
    end

    assign wr = wr_pend_r & ce;
    assign start_wr = wr & hit(wr_addr_r, OFS_TASK_START) & hwdata[0];
    assign stop_wr = wr & hit(wr_addr_r, OFS_TASK_STOP) & hwdata[0];
    assign sample_wr = wr & hit(wr_addr_r, OFS_TASK_SAMPLE) & hwdata[0];
    assign clr = (wr & hit(wr_addr_r, OFS_EVT_CLEAR)) ? hwdata[3:0] : 4'h0;

    always_comb begin
        rd_val = RST_ZERO;
        unique case (haddr[11:0])
            OFS_EVT_READY: rd_val = {31'h0000_0000, evt_r[EV_READY]};
            OFS_EVT_DOWN: rd_val = {31'h0000_0000, evt_r[EV_DOWN]};
            OFS_EVT_UP: rd_val = {31'h0000_0000, evt_r[EV_UP]};
            OFS_EVT_CROSS: rd_val = {31'h0000_0000, evt_r[EV_CROSS]};
            OFS_EVT_STATUS: rd_val = {28'h000_0000, evt_r};
            OFS_SHORTS: rd_val = {27'h000_0000, shorts_r};
            OFS_INTEN, OFS_INTENSET, OFS_INTENCLR: rd_val = {28'h000_0000, inten_r};
            OFS_RESULT: rd_val = {31'h0000_0000, result_r};
            OFS_ENABLE: rd_val = {31'h0000_0000, en_r};
            OFS_PSEL: rd_val = {29'h0000_0000, psel_r};
            OFS_REFERENCE_SOURCE_SELECT: rd_val = {29'h0000_0000, reference_source_select_r};
            OFS_EXTERNAL_REFERENCE_PIN_SELECT: rd_val = {31'h0000_0000, extref_r};
            OFS_THRESH: rd_val = {18'h0_0000, thup_r, 2'h0, thdown_r};
            OFS_MODE: rd_val = {23'h00_0000, diff_r, 6'h00, speed_r};
            OFS_HYSTERESIS_ENABLE: rd_val = {31'h0000_0000, hysteresis_enable_r};
            OFS_CURRENT_SOURCE_SELECT: rd_val = {30'h0000_0000, isrc_r};
            default: rd_val = RST_ZERO;
        endcase
    end

    // read data is captured at the address phase so it stands registered in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= RST_ZERO;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (ce) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready && hsel && htrans[1] && !hwrite) begin
                hrdata <= rd_val;
            end
        end
    end

    // configuration; software is expected to set it before enabling [R17]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shorts_r <= 5'h00;
            psel_r <= 3'h0;
            reference_source_select_r <= REF_INT_1V2;
            extref_r <= 1'b0;
            thdown_r <= RST_THRESH[5:0];
            thup_r <= RST_THRESH[13:8];
            speed_r <= SPEED_LOW_POWER;
            diff_r <= 1'b0;
            hysteresis_enable_r <= 1'b0;
            isrc_r <= 2'h0;
        end else if (wr) begin
            if (hit(wr_addr_r, OFS_SHORTS)) shorts_r <= hwdata[4:0];
            if (hit(wr_addr_r, OFS_PSEL)) psel_r <= hwdata[2:0];
            if (hit(wr_addr_r, OFS_REFERENCE_SOURCE_SELECT)) reference_source_select_r <= hwdata[2:0]; // [R13]
            if (hit(wr_addr_r, OFS_EXTERNAL_REFERENCE_PIN_SELECT)) extref_r <= hwdata[0];
            if (hit(wr_addr_r, OFS_THRESH)) begin
                thdown_r <= hwdata[TH_DOWN_LSB +: 6]; // [R14]
                thup_r <= hwdata[TH_UP_LSB +: 6]; // [R14]
            end
            if (hit(wr_addr_r, OFS_MODE)) begin
                speed_r <= hwdata[MODE_SPEED_LSB +: 2]; // [R15]
                diff_r <= hwdata[MODE_DIFF_BIT]; // [R15]
            end
            if (hit(wr_addr_r, OFS_HYSTERESIS_ENABLE) && diff_r) hysteresis_enable_r <= hwdata[0]; // [R18]
            if (hit(wr_addr_r, OFS_CURRENT_SOURCE_SELECT)) isrc_r <= hwdata[1:0];
        end
    end

    // enable, with mutual exclusion against the low-power comparator
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_r <= 1'b0;
            low_power_comparator_disable <= 1'b0;
        end else if (ce) begin
            low_power_comparator_disable <= 1'b0;
            if (low_power_comparator_enabling) begin
                en_r <= 1'b0; // [R7]
            end else if (wr && hit(wr_addr_r, OFS_ENABLE)) begin
                en_r <= hwdata[0];
                low_power_comparator_disable <= hwdata[0]; // [R7]
            end
        end
    end

    // ready fires once the startup count expires, unless stopped in that cycle
    assign ready_ev = (st_r == ACC_STARTING) && (cnt_r == STARTUP_LAST) && !stop_wr && en_r; // [R2]
    assign up_ev = (st_r == ACC_RUN) && rise; // [R3] [R4]
    assign down_ev = (st_r == ACC_RUN) && fall; // [R3] [R4]
    assign cross_ev = up_ev | down_ev; // [R5]
    assign stop_req = stop_wr | (ready_ev & shorts_r[SH_READY_STOP]) | (down_ev & shorts_r[SH_DOWN_STOP])
        | (up_ev & shorts_r[SH_UP_STOP]) | (cross_ev & shorts_r[SH_CROSS_STOP]);
    assign sample_req = sample_wr | (ready_ev & shorts_r[SH_READY_SAMPLE]);

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            ACC_IDLE: if (start_wr && en_r) st_nxt = ACC_STARTING; // [R1]
            ACC_STARTING: begin
                if (stop_req || !en_r) st_nxt = ACC_IDLE; // [R1] [R9]
                else if (ready_ev) st_nxt = ACC_RUN;
            end
            ACC_RUN: if (stop_req || !en_r) st_nxt = ACC_IDLE; // [R1] [R9]
            default: st_nxt = ACC_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= ACC_IDLE;
            cnt_r <= 11'h000;
        end else if (ce) begin
            st_r <= st_nxt;
            cnt_r <= (st_r == ACC_STARTING) ? cnt_r + 11'h001 : 11'h000;
        end
    end

    // result takes the synchronised level; it lags the core by two cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_r <= 1'b0;
        end else if (ce && sample_req) begin
            result_r <= lvl; // [R6]
        end
    end

    // sticky events; a set in the clearing cycle wins
    assign evt_nxt = (evt_r & ~clr) | {cross_ev, up_ev, down_ev, ready_ev}; // [R19]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_r <= 4'h0;
            inten_r <= 4'h0;
            irq <= 1'b0;
        end else if (ce) begin
            evt_r <= evt_nxt;
            if (wr && hit(wr_addr_r, OFS_INTEN)) inten_r <= hwdata[3:0]; // [R19]
            else if (wr && hit(wr_addr_r, OFS_INTENSET)) inten_r <= inten_r | hwdata[3:0];
            else if (wr && hit(wr_addr_r, OFS_INTENCLR)) inten_r <= inten_r & ~hwdata[3:0];
            irq <= |(evt_r & inten_r); // [R19]
        end
    end

    // analog core control, registered so the core sees glitch-free selects
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ana_ctrl <= '0;
        end else if (ce) begin
            ana_ctrl.power_on <= (st_nxt != ACC_IDLE); // [R1]
            ana_ctrl.diff_mode <= diff_r; // [R15]
            ana_ctrl.speed <= speed_r; // [R15]
            ana_ctrl.hysteresis_enable_on <= diff_r & hysteresis_enable_r; // [R10] [R18]
            ana_ctrl.neg_from_pin_one <= diff_r & extref_r; // [R12]
            ana_ctrl.ref_select <= diff_r ? REF_EXT_PIN : reference_source_select_r; // [R12] [R13]
            ana_ctrl.ext_pin_one <= extref_r; // [R13]
            ana_ctrl.ladder_code <= lvl ? thdown_r : thup_r; // [R11] [R14]
            ana_ctrl.positive_pin <= psel_r;
            ana_ctrl.current_source_select <= isrc_r;
            ana_ctrl.current_sink <= lvl; // [R16]
        end
    end

    property p_start;
        @(posedge hclk) disable iff (!hresetn) (ce && st_r == ACC_IDLE && start_wr && en_r) |=> st_r == ACC_STARTING;
    endproperty
    a_start: assert property (p_start) else $error("start task ignored"); // [R1]

    property p_stop;
        @(posedge hclk) disable iff (!hresetn) (ce && st_r != ACC_IDLE && stop_wr) |=> st_r == ACC_IDLE;
    endproperty
    a_stop: assert property (p_stop) else $error("stop task ignored"); // [R1]

    property p_ready;
        @(posedge hclk) disable iff (!hresetn) ready_ev && ce |-> cnt_r == STARTUP_LAST ##1 evt_r[EV_READY];
    endproperty
    a_ready: assert property (p_ready) else $error("ready event timing wrong"); // [R2]

    property p_quiet;
        @(posedge hclk) disable iff (!hresetn) st_r != ACC_RUN |=> !$rose(evt_r[EV_CROSS]);
    endproperty
    a_quiet: assert property (p_quiet) else $error("crossing event while not running"); // [R3]

    property p_up;
        @(posedge hclk) disable iff (!hresetn) (ce && st_r == ACC_RUN && rise) |=> evt_r[EV_UP] && evt_r[EV_CROSS];
    endproperty
    a_up: assert property (p_up) else $error("up crossing lost"); // [R4]

    property p_down;
        @(posedge hclk) disable iff (!hresetn) (ce && st_r == ACC_RUN && fall)
            |=> evt_r[EV_DOWN] && evt_r[EV_CROSS] && !$rose(evt_r[EV_UP]);
    endproperty
    a_down: assert property (p_down) else $error("down crossing lost"); // [R5]

    property p_sample;
        @(posedge hclk) disable iff (!hresetn) (ce && sample_wr) |=> result_r == $past(lvl);
    endproperty
    a_sample: assert property (p_sample) else $error("sample not captured"); // [R6]

    property p_excl;
        @(posedge hclk) disable iff (!hresetn) (ce && low_power_comparator_enabling) |=> !en_r ##1 !ana_ctrl.power_on;
    endproperty
    a_excl: assert property (p_excl) else $error("exclusion not kept"); // [R7]

    property p_hysteresis_enable;
        @(posedge hclk) disable iff (!hresetn) ana_ctrl.hysteresis_enable_on |-> ana_ctrl.diff_mode;
    endproperty
    a_hysteresis_enable: assert property (p_hysteresis_enable) else $error("hysteresis on in single-ended"); // [R10]

    property p_ladder;
        @(posedge hclk) disable iff (!hresetn) ce |=> ana_ctrl.ladder_code == ($past(lvl) ? $past(thdown_r) : $past(thup_r));
    endproperty
    a_ladder: assert property (p_ladder) else $error("ladder threshold wrong"); // [R11]

    property p_isrc;
        @(posedge hclk) disable iff (!hresetn) ce |=> ana_ctrl.current_sink == $past(lvl);
    endproperty
    a_isrc: assert property (p_isrc) else $error("current direction wrong"); // [R16]

    property p_sticky;
        @(posedge hclk) disable iff (!hresetn) $fell(evt_r[EV_READY]) |-> $past(clr[EV_READY]);
    endproperty
    a_sticky: assert property (p_sticky) else $error("event dropped without clear"); // [R19]

    property p_run_ready;
        @(posedge hclk) disable iff (!hresetn) $rose(st_r == ACC_RUN) |-> evt_r[EV_READY];
    endproperty
    a_run_ready: assert property (p_run_ready) else $error("run entered without ready event"); // [R2]

    property p_start_len;
        @(posedge hclk) disable iff (!hresetn) st_r == ACC_STARTING |-> cnt_r <= STARTUP_LAST;
    endproperty
    a_start_len: assert property (p_start_len) else $error("startup count overran"); // [R2]

    property p_idle_en;
        @(posedge hclk) disable iff (!hresetn) (ce && !en_r) |=> st_r == ACC_IDLE;
    endproperty
    a_idle_en: assert property (p_idle_en) else $error("comparator active while disabled"); // [R1]

    property p_lp_dis;
        @(posedge hclk) disable iff (!hresetn)
            (wr && hit(wr_addr_r, OFS_ENABLE) && hwdata[0] && !low_power_comparator_enabling)
            |=> low_power_comparator_disable;
    endproperty
    a_lp_dis: assert property (p_lp_dis) else $error("other comparator not disabled"); // [R7]

    property p_irq_mask;
        @(posedge hclk) disable iff (!hresetn) (ce && (evt_r & inten_r) == 4'h0) |=> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt without enabled event"); // [R19]

    c_run: cover property (@(posedge hclk) disable iff (!hresetn) st_r == ACC_STARTING ##1 st_r == ACC_RUN);
    c_cross: cover property (@(posedge hclk) disable iff (!hresetn) up_ev ##[1:50] down_ev);
    c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
    c_sample: cover property (@(posedge hclk) disable iff (!hresetn) sample_req ##1 result_r);
    c_excl: cover property (@(posedge hclk) disable iff (!hresetn) low_power_comparator_enabling ##1 !en_r);
endmodule : acc_comparator_ctrl

// [verification/acc_core_model.sv]
// behavioural model of the analog comparator core and its selected input pins
// assumes pin voltages in millivolts from the bench and a fixed supply level
`timescale 1ns/10ps
module acc_core_model import acc_pkg::*; #(
    parameter int SUPPLY_MV = 3000
) (
    input acc_ana_t ana_ctrl,
    input wire logic [15:0] vin_p_mv,
    input wire logic [15:0] vin_n_mv,
    output logic core_out
);
    int vref;
    int vneg;
    int hysteresis_enable;
    initial core_out = 1'b0;
    always @(ana_ctrl or vin_p_mv or vin_n_mv) begin
        case (ana_ctrl.ref_select)
            REF_INT_1V2: vref = 1200;
            REF_INT_1V8: vref = 1800;
            REF_INT_2V4: vref = 2400;
            REF_SUPPLY: vref = SUPPLY_MV;
            default: vref = int'(vin_n_mv);
        endcase
        // ladder of 64 steps over the reference; differential mode takes the pin itself
        vneg = ana_ctrl.diff_mode ? int'(vin_n_mv) : vref * (int'(ana_ctrl.ladder_code) + 1) / 64;
        hysteresis_enable = (ana_ctrl.diff_mode && ana_ctrl.hysteresis_enable_on) ? 25 : 0;
        // an unpowered core gives no valid decision, so it rests low
        if (!ana_ctrl.power_on) begin
            core_out <= 1'b0;
        end else if (core_out) begin
            core_out <= !(int'(vin_p_mv) < vneg - hysteresis_enable);
        end else begin
            core_out <= int'(vin_p_mv) > vneg + hysteresis_enable;
        end
    end
endmodule : acc_core_model

// [verification/analog_comparator_control_tb.sv]
// self-checking bench of the comparator control block
// assumes one 125 MHz clock; the bench plays the single bus master
`timescale 1ns/10ps
module analog_comparator_control_tb import acc_pkg::*;;
    typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e;} acc_row_t;
    logic hclk, hresetn, hsel, hwrite, lp_en, hreadyout, hresp, lp_dis, irq, core_out;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] vin_p, vin_n;
    acc_ana_t ana;
    int n_fail, n_checks, cyc, n_dis, n0, n;
    acc_row_t rows [12] = '{
        '{OFS_PSEL, 32'h0000_0005, 32'h0000_0005}, '{OFS_REFERENCE_SOURCE_SELECT, 32'h0000_0002, 32'h0000_0002},
        '{OFS_EXTERNAL_REFERENCE_PIN_SELECT, 32'h0000_0001, 32'h0000_0001}, '{OFS_THRESH, 32'hFFFF_FFFF, 32'h0000_3F3F},
        '{OFS_MODE, 32'h0000_0102, 32'h0000_0102}, '{OFS_SHORTS, 32'h0000_001F, 32'h0000_001F},
        '{OFS_INTEN, 32'h0000_000F, 32'h0000_000F}, '{OFS_CURRENT_SOURCE_SELECT, 32'h0000_0003, 32'h0000_0003},
        '{12'h600, 32'hFFFF_FFFF, 32'h0000_0000}, '{OFS_EVT_CLEAR, 32'h0000_0000, 32'h0000_0000},
        '{OFS_RESULT, 32'h0000_0001, 32'h0000_0000}, '{OFS_HYSTERESIS_ENABLE, 32'h0000_0001, 32'h0000_0001}};
    acc_comparator_ctrl dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core_out(core_out),
        .low_power_comparator_enabling(lp_en), .low_power_comparator_disable(lp_dis), .ana_ctrl(ana), .irq(irq));
    acc_core_model core (.ana_ctrl(ana), .vin_p_mv(vin_p), .vin_n_mv(vin_n), .core_out(core_out));
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    task automatic complete_run;
        if (n_fail == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one single word transfer; the address phase stands until hready is seen high
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {20'h0_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, a, d, unused);
    endtask : wr
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        bus(1'b0, a, 32'h0000_0000, d);
        chk(d, e);
    endtask : rchk
    task automatic settle(input logic [15:0] p);
        vin_p <= p;
        repeat (8) @(posedge hclk);
    endtask : settle
    always @(posedge hclk) begin
        if (lp_dis === 1'b1) n_dis++;
        cyc++;
        // the whole sequence needs well under this many cycles
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        {hresetn, hsel, hwrite, lp_en, htrans, hsize, haddr, hwdata} = '0;
        vin_p = 16'h0000;
        vin_n = 16'h03E8;
        repeat (20) @(posedge hclk);
        chk(irq, 0);
        chk(ana, 0);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(hreadyout, 1);
        chk(hresp, 0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rchk(rows[i].a, rows[i].e);
        end
        // single-ended setup, all of it before enabling pin one kept away from the adc
        wr(OFS_SHORTS, 32'h0000_0000);
        wr(OFS_PSEL, 32'h0000_0001);
        wr(OFS_REFERENCE_SOURCE_SELECT, 32'h0000_0001);
        wr(OFS_THRESH, 32'h0000_1F0F);
        wr(OFS_MODE, 32'h0000_0001);
        wr(OFS_HYSTERESIS_ENABLE, 32'h0000_0000);
        rchk(OFS_HYSTERESIS_ENABLE, 32'h0000_0001);
        n0 = n_dis;
        wr(OFS_ENABLE, 32'h0000_0001);
        wr(OFS_INTEN, 32'h0000_000F);
        chk(n_dis - n0, 1);
        chk(ana.hysteresis_enable_on, 0);
        wr(OFS_TASK_START, 32'h0000_0001);
        @(posedge hclk);
        chk(ana.power_on, 1);
        for (n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge hclk);
        chk(n >= 1240 && n <= 1260, 1);
        rchk(OFS_EVT_STATUS, 32'h0000_0001);
        wr(OFS_EVT_CLEAR, 32'h0000_000F);
        settle(16'd1500);
        rchk(OFS_EVT_STATUS, 32'h0000_000C);
        chk(ana.ladder_code, 15);
        chk(ana.current_sink, 1);
        chk({ana.positive_pin, ana.ext_pin_one, ana.current_source_select}, 32'h0000_000F);
        wr(OFS_TASK_SAMPLE, 32'h0000_0001);
        rchk(OFS_RESULT, 32'h0000_0001);
        wr(OFS_EVT_CLEAR, 32'h0000_000F);
        settle(16'd200);
        rchk(OFS_EVT_STATUS, 32'h0000_000A);
        chk({ana.ladder_code, ana.current_sink}, {6'd31, 1'b0});
        wr(OFS_TASK_SAMPLE, 32'h0000_0001);
        rchk(OFS_RESULT, 32'h0000_0000);
        wr(OFS_EVT_CLEAR, 32'h0000_000F);
        wr(OFS_INTENCLR, 32'h0000_000F);
        settle(16'd1500);
        rchk(OFS_EVT_STATUS, 32'h0000_000C);
        chk(irq, 0);
        wr(OFS_TASK_STOP, 32'h0000_0001);
        wr(OFS_EVT_CLEAR, 32'h0000_000F);
        chk(ana.power_on, 0);
        settle(16'd200);
        rchk(OFS_EVT_STATUS, 32'h0000_0000);
        // disable only once stopped differential with hysteresis next
        wr(OFS_ENABLE, 32'h0000_0000);
        wr(OFS_MODE, 32'h0000_0100);
        wr(OFS_HYSTERESIS_ENABLE, 32'h0000_0001);
        rchk(OFS_HYSTERESIS_ENABLE, 32'h0000_0001);
        wr(OFS_ENABLE, 32'h0000_0001);
        wr(OFS_TASK_START, 32'h0000_0001);
        repeat (1300) @(posedge hclk);
        chk({ana.diff_mode, ana.hysteresis_enable_on, ana.neg_from_pin_one, ana.ref_select, ana.speed}, 8'b1111_0000);
        wr(OFS_EVT_CLEAR, 32'h0000_000F);
        settle(16'd1010);
        rchk(OFS_EVT_STATUS, 32'h0000_0000);
        settle(16'd1100);
        rchk(OFS_EVT_STATUS, 32'h0000_000C);
        lp_en <= 1'b1;
        @(posedge hclk);
        lp_en <= 1'b0;
        rchk(OFS_ENABLE, 32'h0000_0000);
        chk(ana.power_on, 0);
        hresetn <= 1'b0;
        @(negedge hclk);
        chk({irq, ana}, 0);
        complete_run();
    end
endmodule : analog_comparator_control_tb
